// ==== design/fwd_prio_cfg_pkg.sv ====
// Constants for the forwarding and priority configuration register bank
package fwd_prio_cfg_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_MAP_LO  = 8'h0c;   // Tag priority map, codes 0..3
   localparam logic [7:0] OFF_MAP_HI  = 8'h0d;   // Tag priority map, codes 4..7
   localparam logic [7:0] OFF_UNK_FWD = 8'h0e;   // unknown_dest_forward_ctrl
   localparam logic [7:0] OFF_PHY     = 8'h0f;   // phy_address_base
   localparam logic [7:0] OFF_PORT1   = 8'h10;   // port1_ingress_egress_ctrl
   localparam logic [7:0] OFF_PORT2   = 8'h20;   // port2_ingress_egress_ctrl
   localparam logic [7:0] OFF_PORT3   = 8'h30;   // port3_ingress_egress_ctrl

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_MAP_LO  = 8'h50;   // Codes 3,2 -> 01; codes 1,0 -> 00
   localparam logic [7:0] RST_MAP_HI  = 8'hfa;   // Codes 7,6 -> 11; codes 5,4 -> 10
   localparam logic [7:0] RST_UNK_FWD = 8'h07;   // Disabled, mask all ones
   localparam logic [7:0] RST_PHY     = 8'h08;   // Port 1 PHY address 00001
   localparam logic [7:0] RST_PORT    = 8'h00;   // All per-port features off

   // ****************************************
   // Field positions
   // ****************************************
   localparam int UNK_EN_BIT    = 7;   // Unknown-destination redirect enable
   localparam int UNK_MASK_MSB  = 2;   // Port mask, bit 2 = port 3
   localparam int PHY_MSB       = 7;   // PHY address field top
   localparam int PHY_LSB       = 3;   // PHY address field bottom
   localparam int PHY_RSVD_MSB  = 2;   // Read-only reserved bits top
   localparam int STORM_BIT     = 7;   // Broadcast storm protection
   localparam int DSCP_EN_BIT   = 6;   // DiffServ classification enable
   localparam int TAGP_EN_BIT   = 5;   // 802.1p classification enable
   localparam int PPRIO_MSB     = 4;   // Port priority field top
   localparam int PPRIO_LSB     = 3;   // Port priority field bottom
   localparam int INSERT_BIT    = 2;   // Tag insertion on egress
   localparam int REMOVE_BIT    = 1;   // Tag removal on egress
   localparam int MULTIQ_BIT    = 0;   // Four output queues

   // ****************************************
   // Other constants
   // ****************************************
   localparam logic [7:0] RD_UNMAPPED = 8'h00;   // Read answer for unmapped offsets
   localparam logic [4:0] PHY_STEP    = 5'h01;   // Port 2 address offset from port 1
   localparam int         NUM_PORTS   = 3;       // Switch ports

endpackage : fwd_prio_cfg_pkg

// ==== design/fwd_prio_cfg.sv ====
// Forwarding, PHY address and per-port priority configuration register bank
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Enable bit redirects unknown-destination frames to mask
// R2 - Mask bits 2..0 select ports 3..1, reset ones
// R3 - Five-bit port 1 PHY address, reset 00001
// R4 - Port 2 PHY address is port 1 plus one
// R5 - Same per-port layout at 0x10, 0x20, 0x30
// R6 - Storm protection bit per ingress port, reset 0
// R7 - DiffServ bit classifies IPv4/IPv6 frames by DSCP
// R8 - 802.1p bit classifies tagged frames by user priority
// R9 - Port priority field is fallback queue 0..3
// R10 - OR of 802.1p and DSCP overrides port priority
// R11 - Insert bit tags untagged frames with ingress VID
// R12 - Remove bit strips tags from tagged frames only
// R13 - Multi-queue bit selects four queues, else one
// R14 - Each tag priority code mapped by two-bit field
// R15 - Writes affect decisions made after the write
// R16 - Software keeps reserved bits at default values
module fwd_prio_cfg (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrStb,
   input  wire logic       regRdStb,
   output logic      [7:0] regRdData,
   input  wire logic       fwdReq,
   input  wire logic       fwdUnknown,
   input  wire logic [2:0] fwdDefaultMask,
   output logic            fwdValid,
   output logic      [2:0] fwdMask,
   input  wire logic       clsReq,
   input  wire logic [1:0] clsPort,
   input  wire logic       clsTagged,
   input  wire logic [2:0] clsTagPrio,
   input  wire logic       clsIp,
   input  wire logic       clsDscpHit,
   input  wire logic [1:0] clsDscpPrio,
   output logic            clsValid,
   output logic      [1:0] clsQueue,
   input  wire logic       egrReq,
   input  wire logic [1:0] egrPort,
   input  wire logic       egrTagged,
   output logic            egrValid,
   output logic            egrInsert,
   output logic            egrRemove,
   output logic      [4:0] phyAddrPort1,
   output logic      [4:0] phyAddrPort2,
   output logic      [2:0] stormProtEn,
   output logic      [2:0] multiQueueEn
);

   // ****************************************
   // Register storage
   // ****************************************
   logic [7:0] mapLo;                                      // Tag codes 0..3
   logic [7:0] mapHi;                                      // Tag codes 4..7
   logic [7:0] unkFwd;                                     // Unknown-destination control
   logic [7:0] phyBase;                                    // PHY address base
   logic [7:0] portCtrl [0:fwd_prio_cfg_pkg::NUM_PORTS-1]; // One copy per port

   // Port number 0..2 means port 1..3; code 3 is folded onto port 3
   function automatic logic [1:0] portIndex(input logic [1:0] code);
      portIndex = (code == 2'h3) ? 2'h2 : code;
   endfunction : portIndex

   // Look up the queue for a tag priority code in the map registers
   function automatic logic [1:0] tagPrioMap(input logic [2:0] code,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
      logic [7:0] half;
      half = code[2] ? hi : lo;
      tagPrioMap = half[{code[1:0], 1'b0} +: 2];
   endfunction : tagPrioMap

   // ****************************************
   // Address decode
   // ****************************************
   wire hitMapLo = regAddr == fwd_prio_cfg_pkg::OFF_MAP_LO;
   wire hitMapHi = regAddr == fwd_prio_cfg_pkg::OFF_MAP_HI;
   wire hitUnk   = regAddr == fwd_prio_cfg_pkg::OFF_UNK_FWD;
   wire hitPhy   = regAddr == fwd_prio_cfg_pkg::OFF_PHY;
   wire hitP1    = regAddr == fwd_prio_cfg_pkg::OFF_PORT1;   // R5
   wire hitP2    = regAddr == fwd_prio_cfg_pkg::OFF_PORT2;   // R5
   wire hitP3    = regAddr == fwd_prio_cfg_pkg::OFF_PORT3;   // R5
   wire [2:0] hitPort = {hitP3, hitP2, hitP1};

   // Reserved PHY bits are read-only zero, so a write cannot set them
   wire [7:0] phyWrVal = {regWrData[fwd_prio_cfg_pkg::PHY_MSB:fwd_prio_cfg_pkg::PHY_LSB],
                          3'h0};

   // Read multiplexer; unmapped offsets answer zero
   wire [7:0] next_regRdData =
      hitMapLo ? mapLo :
      hitMapHi ? mapHi :
      hitUnk   ? unkFwd :
      hitPhy   ? phyBase :
      hitP1    ? portCtrl[0] :
      hitP2    ? portCtrl[1] :
      hitP3    ? portCtrl[2] : fwd_prio_cfg_pkg::RD_UNMAPPED;

   // ****************************************
   // Field views
   // ****************************************
   wire       unkEn   = unkFwd[fwd_prio_cfg_pkg::UNK_EN_BIT];      // R1
   wire [2:0] unkMask = unkFwd[fwd_prio_cfg_pkg::UNK_MASK_MSB:0];  // R2
   wire [4:0] phyAddr = phyBase[fwd_prio_cfg_pkg::PHY_MSB:fwd_prio_cfg_pkg::PHY_LSB]; // R3

   // Ingress port selected by the classification request
   wire [7:0] clsCtrl = portCtrl[portIndex(clsPort)];
   wire       dscpEn  = clsCtrl[fwd_prio_cfg_pkg::DSCP_EN_BIT];
   wire       tagpEn  = clsCtrl[fwd_prio_cfg_pkg::TAGP_EN_BIT];
   wire [1:0] portPrio = clsCtrl[fwd_prio_cfg_pkg::PPRIO_MSB:fwd_prio_cfg_pkg::PPRIO_LSB];

   // A method classifies only when enabled and the frame carries its field
   wire       dscpHit = dscpEn && clsIp && clsDscpHit;                  // R7
   wire       tagpHit = tagpEn && clsTagged;                            // R8
   wire [1:0] tagpQ   = tagPrioMap(clsTagPrio, mapLo, mapHi);          // R14
   wire [1:0] orQ     = (dscpHit ? clsDscpPrio : 2'h0) | (tagpHit ? tagpQ : 2'h0); // R10
   wire [1:0] next_clsQueue = (dscpHit || tagpHit) ? orQ : portPrio;    // R9

   // Egress port decisions
   wire [7:0] egrCtrl = portCtrl[portIndex(egrPort)];
   wire next_egrInsert = egrCtrl[fwd_prio_cfg_pkg::INSERT_BIT] && !egrTagged;  // R11
   wire next_egrRemove = egrCtrl[fwd_prio_cfg_pkg::REMOVE_BIT] && egrTagged;   // R12

   // Unknown destinations follow the mask only while redirection is on
   wire [2:0] next_fwdMask = (fwdUnknown && unkEn) ? unkMask : fwdDefaultMask; // R1

   // ****************************************
   // Global registers
   // ****************************************
   // Reserved bits of the unknown control are stored as written; software keeps them
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mapLo   <= fwd_prio_cfg_pkg::RST_MAP_LO;    // R14
         mapHi   <= fwd_prio_cfg_pkg::RST_MAP_HI;    // R14
         unkFwd  <= fwd_prio_cfg_pkg::RST_UNK_FWD;   // R1
         phyBase <= fwd_prio_cfg_pkg::RST_PHY;       // R3
      end else begin
         if (regWrStb && hitMapLo) mapLo   <= regWrData;
         if (regWrStb && hitMapHi) mapHi   <= regWrData;
         if (regWrStb && hitUnk)   unkFwd  <= regWrData;  // R16
         if (regWrStb && hitPhy)   phyBase <= phyWrVal;   // R3
      end
   end

   // ****************************************
   // Per-port registers
   // ****************************************
   // One write decode per copy; all copies share the same layout
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < fwd_prio_cfg_pkg::NUM_PORTS; i++) begin
            portCtrl[i] <= fwd_prio_cfg_pkg::RST_PORT;    // R6 R13
         end
      end else begin
         for (int i = 0; i < fwd_prio_cfg_pkg::NUM_PORTS; i++) begin
            if (regWrStb && hitPort[i]) portCtrl[i] <= regWrData;  // R5
         end
      end
   end

   // ****************************************
   // Read data and derived configuration
   // ****************************************
   // Read data stands for exactly one cycle after the strobe, else zero
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData    <= 8'h00;
         phyAddrPort1 <= 5'h01;
         phyAddrPort2 <= 5'h02;
         stormProtEn  <= 3'h0;
         multiQueueEn <= 3'h0;
      end else begin
         regRdData    <= regRdStb ? next_regRdData : 8'h00;
         phyAddrPort1 <= phyAddr;                                   // R3
         phyAddrPort2 <= phyAddr + fwd_prio_cfg_pkg::PHY_STEP;      // R4
         for (int i = 0; i < fwd_prio_cfg_pkg::NUM_PORTS; i++) begin
            stormProtEn[i]  <= portCtrl[i][fwd_prio_cfg_pkg::STORM_BIT];   // R6
            multiQueueEn[i] <= portCtrl[i][fwd_prio_cfg_pkg::MULTIQ_BIT];  // R13
         end
      end
   end

   // ****************************************
   // Decision answers
   // ****************************************
   // Decisions read the registers as they stand at the request edge, so a
   // completed write is seen by every later request
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         fwdValid  <= 1'b0;
         fwdMask   <= 3'h0;
         clsValid  <= 1'b0;
         clsQueue  <= 2'h0;
         egrValid  <= 1'b0;
         egrInsert <= 1'b0;
         egrRemove <= 1'b0;
      end else begin
         fwdValid  <= fwdReq;
         fwdMask   <= fwdReq ? next_fwdMask : 3'h0;      // R15
         clsValid  <= clsReq;
         clsQueue  <= clsReq ? next_clsQueue : 2'h0;     // R15
         egrValid  <= egrReq;
         egrInsert <= egrReq && next_egrInsert;
         egrRemove <= egrReq && next_egrRemove;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence sUnkOn;
      fwdReq && fwdUnknown && unkEn;
   endsequence
   sequence sUnkOff;
      fwdReq && !unkEn;
   endsequence
   sequence sWrUnk;
      regWrStb && hitUnk;
   endsequence
   sequence sWrPhy;
      regWrStb && hitPhy;
   endsequence
   sequence sWrPort3;
      regWrStb && hitP3;
   endsequence

   AST_UNK_REDIRECT: assert property (sUnkOn |=> fwdValid && fwdMask == $past(unkMask)) // R1
      else $error("unknown frame not sent to mask");
   AST_UNK_OFF: assert property (sUnkOff |=> fwdMask == $past(fwdDefaultMask)) // R1
      else $error("redirect active while disabled");
   AST_MASK_WRITE: assert property (sWrUnk ##1 fwdReq && fwdUnknown // R2
         |=> fwdMask == $past(regWrData[2:0], 2) || !$past(unkEn))
      else $error("mask write not honoured");
   AST_PHY_PLUS_ONE: assert property (##1 // R4
         phyAddrPort2 == $past(phyAddr) + fwd_prio_cfg_pkg::PHY_STEP)
      else $error("port 2 PHY address mismatch");
   AST_PORT_READ: assert property (regRdStb && hitP2 |=> regRdData == portCtrl[1]) // R5
      else $error("port 2 control readback wrong");
   AST_PORT_PRIO: assert property (clsReq && !dscpHit && !tagpHit // R9
         |=> clsValid && clsQueue == $past(portPrio))
      else $error("fallback queue wrong");
   AST_OR_PRIO: assert property (clsReq && dscpHit && tagpHit // R10
         |=> clsQueue == ($past(clsDscpPrio) | $past(tagpQ)))
      else $error("combined priority wrong");
   AST_INSERT: assert property (egrReq && !egrTagged // R11
         && egrCtrl[fwd_prio_cfg_pkg::INSERT_BIT]
         |=> egrValid && egrInsert && !egrRemove)
      else $error("tag not inserted");
   AST_REMOVE: assert property (egrReq && egrTagged |=> !egrInsert // R12
         ##0 egrRemove == $past(egrCtrl[fwd_prio_cfg_pkg::REMOVE_BIT]))
      else $error("tag removal wrong");
   AST_STORM: assert property (regWrStb && hitP1 ##1 1'b1 // R6
         |=> stormProtEn[0] == $past(regWrData[7], 2))
      else $error("storm enable not applied");

   // ****************************************
   // Guards on idle answers, known destinations, single-method classification, untagged egress and register write and read paths
   // ****************************************
   // Known destinations never follow the redirect mask
   AST_KNOWN_DEST: assert property (fwdReq && !fwdUnknown // R1
         |=> fwdValid && fwdMask == $past(fwdDefaultMask))
      else $error("known destination redirected");
   // Answers rest at zero between requests, so no stale decision leaks out
   AST_FWD_IDLE: assert property (!fwdReq |=> !fwdValid && fwdMask == 3'h0) // R1
      else $error("forwarding answer without request");
   // A PHY address write reaches the port 1 output one cycle after it lands
   AST_PHY_WRITE: assert property (sWrPhy ##1 1'b1 // R3
         |=> phyAddrPort1 == ($past(regWrData, 2) >> fwd_prio_cfg_pkg::PHY_LSB))
      else $error("PHY address write not applied");
   // Reserved low bits of the PHY register always read back as zero
   AST_PHY_RSVD: assert property (regRdStb && hitPhy // R3
         |=> regRdData[fwd_prio_cfg_pkg::PHY_RSVD_MSB:0] == 3'h0)
      else $error("reserved PHY bits not zero");
   // Port 3 copy answers from its own address
   AST_PORT3_READ: assert property (regRdStb && hitP3 // R5
         |=> regRdData == $past(portCtrl[2]))
      else $error("port 3 control readback wrong");
   // Read data stands for one cycle only
   AST_RD_IDLE: assert property (!regRdStb |=> regRdData == 8'h00) // R5
      else $error("read data without strobe");
   // DSCP alone decides when the tag method does not apply
   AST_DSCP_ONLY: assert property (clsReq && dscpHit && !tagpHit // R7
         |=> clsValid && clsQueue == $past(clsDscpPrio))
      else $error("DSCP queue wrong");
   // Frames that are not IP never take the DSCP result
   AST_NOT_IP: assert property (clsReq && !clsIp && !tagpHit // R7
         |=> clsQueue == $past(portPrio))
      else $error("DSCP used on non-IP frame");
   // The mapped tag priority alone decides when DSCP does not apply
   AST_TAG_ONLY: assert property (clsReq && tagpHit && !dscpHit // R8
         |=> clsValid && clsQueue == $past(tagpQ))
      else $error("tag priority queue wrong");
   // Untagged frames never take the tag map
   AST_UNTAGGED: assert property (clsReq && !clsTagged && !dscpHit // R8
         |=> clsQueue == $past(portPrio))
      else $error("tag map used on untagged frame");
   AST_CLS_IDLE: assert property (!clsReq |=> !clsValid && clsQueue == 2'h0) // R9
      else $error("classification answer without request");
   // The multi-queue output follows a port 3 write one cycle after it lands
   AST_MULTIQ: assert property (sWrPort3 ##1 1'b1 // R13
         |=> multiQueueEn[2] == $past(regWrData[fwd_prio_cfg_pkg::MULTIQ_BIT], 2))
      else $error("multi-queue enable not applied");
   // Untagged frames are never stripped
   AST_KEEP_UNTAGGED: assert property (egrReq && !egrTagged |=> !egrRemove) // R12
      else $error("tag removed from untagged frame");
   AST_EGR_IDLE: assert property (!egrReq |=> !egrValid && !egrInsert && !egrRemove) // R11
      else $error("egress answer without request");

endmodule : fwd_prio_cfg

// ==== testbench/test_switch_forwarding_priority_config.sv ====
// Self-checking bench for the forwarding and priority configuration bank
`timescale 1ns/1ps
module test_switch_forwarding_priority_config;
   logic       clock, sys_rst, regWrStb, regRdStb, fwdReq, fwdUnknown, fwdValid;
   logic       clsReq, clsTagged, clsIp, clsDscpHit, clsValid;
   logic       egrReq, egrTagged, egrValid, egrInsert, egrRemove;
   logic [7:0] regAddr, regWrData, regRdData;
   logic [2:0] fwdDefaultMask, fwdMask, clsTagPrio, stormProtEn, multiQueueEn;
   logic [1:0] clsPort, clsDscpPrio, clsQueue, egrPort;
   logic [4:0] phyAddrPort1, phyAddrPort2;
   int         errors, checked, cycles;
   // Register rows: address, write data, reset value, read-back value
   logic [31:0] regRows [8] = '{32'h0c1b_501b, 32'h0de4_fae4, 32'h0e82_0782, 32'h0fe8_08e8,
      32'h10a5_00a5, 32'h205a_005a, 32'h307f_007f, 32'h40ff_0000};
   // Class rows: ctrl, port, tagged, tag prio, ip, hit, dscp prio, queue
   logic [19:0] clsRows [8] = '{20'h18_003, 20'h48_03a, 20'h48_019, 20'h28_613,
      20'h28_411, 20'h60_3b7, 20'h10_3fe, 20'h48_82d};

   fwd_prio_cfg fwd_prio_cfg_inst (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .fwdReq(fwdReq), .fwdUnknown(fwdUnknown), .fwdDefaultMask(fwdDefaultMask),
      .fwdValid(fwdValid), .fwdMask(fwdMask), .clsReq(clsReq), .clsPort(clsPort),
      .clsTagged(clsTagged), .clsTagPrio(clsTagPrio), .clsIp(clsIp), .clsDscpHit(clsDscpHit),
      .clsDscpPrio(clsDscpPrio), .clsValid(clsValid), .clsQueue(clsQueue), .egrReq(egrReq),
      .egrPort(egrPort), .egrTagged(egrTagged), .egrValid(egrValid), .egrInsert(egrInsert),
      .egrRemove(egrRemove), .phyAddrPort1(phyAddrPort1), .phyAddrPort2(phyAddrPort2),
      .stormProtEn(stormProtEn), .multiQueueEn(multiQueueEn));

   // ********************
   // Clock and hang guard
   // ********************
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Whole run needs well under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         wrap_up();
      end
   end

   // ********************
   // Shared tasks
   // ********************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // One-cycle write; strobe dropped at the next edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clock);
      regWrStb <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge clock);
      regRdStb <= 1'b0;
      #1 chk("regRdData", exp, regRdData);
   endtask : rd
   task automatic fwd(input logic u, input logic [2:0] dm, input logic [2:0] exp);
      @(posedge clock);
      fwdReq <= 1'b1;
      fwdUnknown <= u;
      fwdDefaultMask <= dm;
      @(posedge clock);
      fwdReq <= 1'b0;
      #1 chk("fwdValid", 8'h01, {7'h00, fwdValid});
      chk("fwdMask", {5'h00, exp}, {5'h00, fwdMask});
   endtask : fwd
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // ********************
   // Main sequence
   // ********************
   initial begin
      sys_rst = 1'b1;
      {regWrStb, regRdStb, fwdReq, fwdUnknown, clsReq, clsTagged} = 6'h00;
      {clsIp, clsDscpHit, egrReq, egrTagged, regAddr, regWrData} = 20'h0_0000;
      {fwdDefaultMask, clsTagPrio, clsPort, clsDscpPrio, egrPort} = 12'h000;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      #1 chk("phy1", 8'h01, {3'h0, phyAddrPort1});
      chk("phy2", 8'h02, {3'h0, phyAddrPort2});
      chk("storm", 8'h00, {5'h00, stormProtEn});
      chk("multiq", 8'h00, {5'h00, multiQueueEn});
      // Reset values, then write and read back, unmapped place included
      foreach (regRows[i]) rd(regRows[i][31:24], regRows[i][15:8]);
      foreach (regRows[i]) begin
         wr(regRows[i][31:24], regRows[i][23:16]);
         rd(regRows[i][31:24], regRows[i][7:0]);
      end
      @(posedge clock);
      #1 chk("phy1", 8'h1d, {3'h0, phyAddrPort1});
      chk("phy2", 8'h1e, {3'h0, phyAddrPort2});
      chk("storm", 8'h01, {5'h00, stormProtEn});
      chk("multiq", 8'h05, {5'h00, multiQueueEn});
      $display("test registers done");
      // Redirect on unknown destination only when enabled
      wr(8'h0e, 8'h85);
      fwd(1'b1, 3'b010, 3'b101);
      fwd(1'b0, 3'b010, 3'b010);
      wr(8'h0e, 8'h05);
      fwd(1'b1, 3'b010, 3'b010);
      // Write and request in the same cycle: old setting still rules
      @(posedge clock);
      {regAddr, regWrData, regWrStb} <= {8'h0e, 8'h86, 1'b1};
      {fwdReq, fwdUnknown, fwdDefaultMask} <= {1'b1, 1'b1, 3'b001};
      @(posedge clock);
      {regWrStb, fwdReq} <= 2'b00;
      #1 chk("fwdMask", 8'h01, {5'h00, fwdMask});
      fwd(1'b1, 3'b001, 3'b110);
      @(posedge clock);
      #1 chk("fwdValid", 8'h00, {7'h00, fwdValid});
      $display("test forwarding done");
      // Classification rows with the rewritten tag map 3,2,1,0,0,1,2,3
      foreach (clsRows[i]) begin
         wr({2'b00, clsRows[i][11:10] + 2'b01, 4'h0}, clsRows[i][19:12]);
         @(posedge clock);
         {clsReq, clsPort, clsTagged, clsTagPrio} <= {1'b1, clsRows[i][11:6]};
         {clsIp, clsDscpHit, clsDscpPrio} <= clsRows[i][5:2];
         @(posedge clock);
         clsReq <= 1'b0;
         #1 chk("clsValid", 8'h01, {7'h00, clsValid});
         chk("clsQueue", {6'h00, clsRows[i][1:0]}, {6'h00, clsQueue});
      end
      $display("test classification done");
      // Egress edits for insert-only and remove-only settings on port 2
      foreach (regRows[i]) if (i < 4) begin
         wr(8'h20, i[1] ? 8'h02 : 8'h04);
         @(posedge clock);
         {egrReq, egrPort, egrTagged} <= {1'b1, 2'b01, i[0]};
         @(posedge clock);
         egrReq <= 1'b0;
         #1 chk("egrValid", 8'h01, {7'h00, egrValid});
         chk("egrInsert", {7'h00, !i[1] && !i[0]}, {7'h00, egrInsert});
         chk("egrRemove", {7'h00, i[1] && i[0]}, {7'h00, egrRemove});
      end
      $display("test egress done");
      // Mid-run reset returns registers and derived outputs to their defaults
      wr(8'h30, 8'h81);
      wr(8'h0f, 8'h50);
      @(posedge clock);
      sys_rst <= 1'b1;
      @(posedge clock);
      #1 chk("storm", 8'h00, {5'h00, stormProtEn});
      chk("multiq", 8'h00, {5'h00, multiQueueEn});
      chk("phy2", 8'h02, {3'h0, phyAddrPort2});
      @(posedge clock);
      sys_rst <= 1'b0;
      rd(8'h30, 8'h00);
      rd(8'h0f, 8'h08);
      rd(8'h0e, 8'h07);
      @(posedge clock);
      #1 chk("regRdData", 8'h00, regRdData);
      $display("test reset done");
      wrap_up();
   end
endmodule : test_switch_forwarding_priority_config
